// *** verilog/tx_pkg.sv ***
// Purpose: shared constants and types for the transmit command path, plus
//          the host half-word pairing stage
// Assumes: host bus strobes are produced by logic on clk
// Notes:   command field positions are collected here
//
// How it works
// - each buffer starts with two 32-bit command words steering its handling
// - packet tag from command B is copied into the status word
// - differing tags inside one packet raise the transmit error flag
// - bytes received per packet are counted and checked against length
// - command B must match across buffers of a packet, else error
// - payload starts at the offset byte within first 8 words; earlier dropped
// - every following buffer may start at any byte via its own offset
// - padding words up to end alignment are accepted and discarded
// - interrupt-on-completion buffers pulse done as their last byte is offered to the mac
// - one status word per finished packet goes into the status FIFO while it has room
// - optional interrupt when waiting status words reach programmed count
// - writing into a full data FIFO raises the transmit error flag
// - two 16-bit host writes, low half first, form each 32-bit word
// - packet boundaries come only from command word control bits
// - end alignment bits 25:24; 00 four bytes, 01 sixteen bytes

package tx_pkg;
	localparam int IOC_BIT   = 31;
	localparam int ALIGN_HI  = 25;
	localparam int ALIGN_LO  = 24;
	localparam int OFF_HI    = 20;
	localparam int OFF_LO    = 16;
	localparam int FIRST_BIT = 13;
	localparam int LAST_BIT  = 12;
	localparam int SIZE_HI   = 10;
	localparam int SIZE_LO   = 0;
	localparam int TAG_HI    = 31;
	localparam int TAG_LO    = 16;
	localparam int LEN_HI    = 10;
	localparam int LEN_LO    = 0;
	localparam int STAT_ERR  = 15;

	localparam logic [1:0] ALIGN_16  = 2'h1;
	localparam logic [1:0] LANE_LOW  = 2'h0;
	localparam logic [1:0] LANE_HIGH = 2'h3;

	typedef enum logic [1:0] {
		ST_CMD_A = 2'b00,
		ST_CMD_B = 2'b01,
		ST_DATA  = 2'b10,
		ST_PAD   = 2'b11
	} parse_state_t;

	typedef struct packed {
		logic [15:0] data;
		logic        wr;
	} host_write_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  first_lane;
		logic [1:0]  last_lane;
		logic        buf_end;
		logic        ioc;
		logic        pkt_end;
		logic        err;
		logic [15:0] tag;
	} fifo_entry_t;
endpackage

`timescale 1ns/1ps

module half_pair_assembler (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// host half-word writes
	input  wire tx_pkg::host_write_t hw,
	// assembled word
	output logic                    word_valid,
	output logic [31:0]             word
);
	logic        have_low_reg;
	logic [15:0] low_reg;

	// low half first, high half completes the word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			have_low_reg <= 1'b0;
			low_reg      <= 16'h0000;
			word_valid   <= 1'b0;
			word         <= 32'h00000000;
		end else begin
			word_valid <= 1'b0;
			if (hw.wr) begin
				if (have_low_reg) begin
					word       <= {hw.data, low_reg};
					word_valid <= 1'b1;
					have_low_reg <= 1'b0;
				end else begin
					low_reg      <= hw.data;
					have_low_reg <= 1'b1;
				end
			end
		end
	end

	a_pair_forms_word: assert property (@(posedge clk) disable iff (!rst_n)
		hw.wr && have_low_reg |=> word_valid && word[15:0] == $past(low_reg))
		else $error("paired host writes did not form a word");
endmodule

// *** verilog/tx_buffer_command_path.sv ***
// Purpose: transmit command parser, byte stripper, data and status FIFOs
// Assumes: buffer size field nonzero; host keeps command order
// Notes:   byte output drains one byte a cycle under ready back-pressure

`timescale 1ns/1ps

module tx_buffer_command_path #(
	parameter int DEPTH  = 512,
	parameter int SDEPTH = 8
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// host write port
	input  wire tx_pkg::host_write_t host_wr,
	// status fifo read and interrupt control
	input  wire logic                status_pop,
	input  wire logic [7:0]          status_threshold,
	input  wire logic                status_irq_en,
	input  wire logic                err_clear,
	// byte stream toward the mac
	input  wire logic                tx_byte_ready,
	output logic                     tx_byte_valid,
	output logic [7:0]               tx_byte,
	output logic                     tx_byte_last,
	// status and flags
	output logic                     status_valid,
	output logic [31:0]              status_word,
	output logic                     status_irq,
	output logic                     tx_done_irq,
	output logic                     transmit_error_flag,
	output logic [$clog2(DEPTH):0]   tx_fifo_space_info
);
	localparam int AW = $clog2(DEPTH);
	localparam int SW = $clog2(SDEPTH);

	logic        word_valid;
	logic [31:0] word;

	half_pair_assembler u_pair (
		.clk       (clk),
		.rst_n     (rst_n),
		.hw        (host_wr),
		.word_valid(word_valid),
		.word      (word)
	);

	// parser state
	tx_pkg::parse_state_t state_reg;
	logic [31:0] cmd_a_reg;
	logic [31:0] cmd_b_reg;
	logic [31:0] ref_b_reg;
	logic [9:0]  wcnt_reg;
	logic [11:0] byte_acc_reg;
	logic        pkt_err_reg;

	// buffer geometry from command A
	logic [4:0]  off;
	logic [10:0] bsize;
	logic [11:0] end_pos;
	logic [9:0]  start_word;
	logic [9:0]  end_word;
	logic [9:0]  last_idx;
	logic        first_seg;
	logic        last_seg;
	logic [11:0] acc_sum;
	logic        len_bad;
	logic        b_bad;

	always_comb begin
		off        = cmd_a_reg[tx_pkg::OFF_HI:tx_pkg::OFF_LO];
		bsize      = cmd_a_reg[tx_pkg::SIZE_HI:tx_pkg::SIZE_LO];
		end_pos    = 12'({7'h00, off}) + 12'({1'b0, bsize}) - 12'h001;
		start_word = {7'h00, off[4:2]};
		end_word   = end_pos[11:2];
		if (cmd_a_reg[tx_pkg::ALIGN_HI:tx_pkg::ALIGN_LO] == tx_pkg::ALIGN_16)
			last_idx = {end_word[9:2], 2'h3};
		else
			last_idx = end_word;
		first_seg = cmd_a_reg[tx_pkg::FIRST_BIT];
		last_seg  = cmd_a_reg[tx_pkg::LAST_BIT];
		acc_sum   = byte_acc_reg + 12'({1'b0, bsize});
		len_bad   = acc_sum !=
			12'({1'b0, ref_b_reg[tx_pkg::LEN_HI:tx_pkg::LEN_LO]});
		b_bad     = !first_seg && word != ref_b_reg;
	end

	// data fifo
	tx_pkg::fifo_entry_t mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic [AW:0] count;
	logic        full;
	logic        empty;
	logic        in_data;
	logic        push_req;
	logic        push;
	logic        pop;
	logic        at_end;
	tx_pkg::fifo_entry_t new_entry;
	tx_pkg::fifo_entry_t head;

	always_comb begin
		count    = wr_ptr_reg - rd_ptr_reg;
		full     = count == (AW+1)'(DEPTH);
		empty    = count == '0;
		in_data  = state_reg == tx_pkg::ST_DATA && word_valid;
		at_end   = wcnt_reg == end_word;
		push_req = in_data && wcnt_reg >= start_word;
		push     = push_req && !full;
		head     = mem[rd_ptr_reg[AW-1:0]];
		new_entry.data       = word;
		new_entry.first_lane = (wcnt_reg == start_word) ? off[1:0]
			: tx_pkg::LANE_LOW;
		new_entry.last_lane  = at_end ? end_pos[1:0] : tx_pkg::LANE_HIGH;
		new_entry.buf_end    = at_end;
		new_entry.ioc        = cmd_a_reg[tx_pkg::IOC_BIT];
		new_entry.pkt_end    = at_end && last_seg;
		new_entry.err        = pkt_err_reg || (at_end && last_seg && len_bad);
		new_entry.tag        = ref_b_reg[tx_pkg::TAG_HI:tx_pkg::TAG_LO];
	end

	// command and payload parsing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= tx_pkg::ST_CMD_A;
			cmd_a_reg <= 32'h00000000;
			cmd_b_reg <= 32'h00000000;
			wcnt_reg  <= 10'h000;
		end else if (word_valid) begin
			unique case (state_reg)
				tx_pkg::ST_CMD_A: begin
					cmd_a_reg <= word;
					state_reg <= tx_pkg::ST_CMD_B;
				end
				tx_pkg::ST_CMD_B: begin
					cmd_b_reg <= word;
					wcnt_reg  <= 10'h000;
					state_reg <= tx_pkg::ST_DATA;
				end
				tx_pkg::ST_DATA, tx_pkg::ST_PAD: begin
					wcnt_reg <= wcnt_reg + 10'h001;
					if (wcnt_reg == last_idx)
						state_reg <= tx_pkg::ST_CMD_A;
					else if (state_reg == tx_pkg::ST_DATA && at_end)
						state_reg <= tx_pkg::ST_PAD;
				end
			endcase
		end
	end

	// per-packet reference command B, byte count and error
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_b_reg    <= 32'h00000000;
			byte_acc_reg <= 12'h000;
			pkt_err_reg  <= 1'b0;
		end else if (word_valid && state_reg == tx_pkg::ST_CMD_B) begin
			if (first_seg) begin
				ref_b_reg    <= word;
				byte_acc_reg <= 12'h000;
				pkt_err_reg  <= 1'b0;
			end else if (b_bad) begin
				pkt_err_reg <= 1'b1;
			end
		end else if (in_data) begin
			if (push_req && full)
				pkt_err_reg <= 1'b1;
			if (at_end) begin
				byte_acc_reg <= acc_sum;
				if (last_seg)
					pkt_err_reg <= 1'b0;
			end
		end
	end

	// sticky error flag, a new event wins over a clear
	logic err_set;
	assign err_set = (word_valid && state_reg == tx_pkg::ST_CMD_B && b_bad)
		|| (push_req && full) || (in_data && at_end && last_seg && len_bad);

	always_ff @(posedge clk) begin
		if (!rst_n)
			transmit_error_flag <= 1'b0;
		else
			transmit_error_flag <= err_set
				|| (transmit_error_flag && !err_clear);
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg[AW-1:0]] <= new_entry;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			wr_ptr_reg <= '0;
		else if (push)
			wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
	end

	// free space seen by the host before it writes
	always_ff @(posedge clk) begin
		if (!rst_n)
			tx_fifo_space_info <= (AW+1)'(DEPTH);
		else
			tx_fifo_space_info <= (AW+1)'(DEPTH) - count;
	end

	// byte drain toward the mac
	logic [1:0] lane_reg;
	logic       lane_live_reg;
	logic [1:0] cur_lane;
	logic       load;
	logic       entry_done;

	always_comb begin
		cur_lane   = lane_live_reg ? lane_reg : head.first_lane;
		load       = (!tx_byte_valid || tx_byte_ready) && !empty;
		entry_done = cur_lane == head.last_lane;
		pop        = load && entry_done;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_byte_valid <= 1'b0;
			tx_byte       <= 8'h00;
			tx_byte_last  <= 1'b0;
			lane_reg      <= tx_pkg::LANE_LOW;
			lane_live_reg <= 1'b0;
		end else if (load) begin
			tx_byte_valid <= 1'b1;
			tx_byte       <= head.data[{cur_lane, 3'h0} +: 8];
			tx_byte_last  <= head.pkt_end && entry_done;
			lane_reg      <= cur_lane + 2'h1;
			lane_live_reg <= !entry_done;
		end else if (tx_byte_ready) begin
			tx_byte_valid <= 1'b0;
			tx_byte_last  <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			rd_ptr_reg <= '0;
		else if (pop)
			rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
	end

	// completion pulse for buffers asking for it
	always_ff @(posedge clk) begin
		if (!rst_n)
			tx_done_irq <= 1'b0;
		else
			tx_done_irq <= pop && head.buf_end && head.ioc;
	end

	// status fifo
	logic [31:0] smem [SDEPTH];
	logic [SW:0] s_wr_reg;
	logic [SW:0] s_rd_reg;
	logic [SW:0] scount;
	logic        s_push;
	logic        s_pop;
	logic [31:0] s_new;

	always_comb begin
		scount = s_wr_reg - s_rd_reg;
		s_push = pop && head.pkt_end && scount != (SW+1)'(SDEPTH);
		s_pop  = status_pop && scount != '0;
		s_new  = 32'h00000000;
		s_new[tx_pkg::TAG_HI:tx_pkg::TAG_LO] = head.tag;
		s_new[tx_pkg::STAT_ERR] = head.err;
	end

	always_ff @(posedge clk) begin
		if (s_push)
			smem[s_wr_reg[SW-1:0]] <= s_new;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_wr_reg <= '0;
			s_rd_reg <= '0;
		end else begin
			if (s_push)
				s_wr_reg <= s_wr_reg + (SW+1)'(1);
			if (s_pop)
				s_rd_reg <= s_rd_reg + (SW+1)'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_valid <= 1'b0;
			status_word  <= 32'h00000000;
			status_irq   <= 1'b0;
		end else begin
			status_valid <= scount != '0;
			status_word  <= (scount != '0) ? smem[s_rd_reg[SW-1:0]]
				: 32'h00000000;
			status_irq   <= status_irq_en && status_threshold != 8'h00
				&& 8'(scount) >= status_threshold;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_cmd_a_taken;
		state_reg == tx_pkg::ST_CMD_A && word_valid;
	endsequence

	sequence s_cmd_b_taken;
		state_reg == tx_pkg::ST_CMD_B && word_valid;
	endsequence

	a_cmd_pair_order: assert property (
		s_cmd_a_taken ##[1:8] s_cmd_b_taken |=> state_reg == tx_pkg::ST_DATA
		&& cmd_b_reg == $past(word) && wcnt_reg == 10'h000)
		else $error("command pair did not lead to payload");
	a_cmdb_mismatch: assert property (
		s_cmd_b_taken and (!first_seg && word != ref_b_reg)
		|=> transmit_error_flag)
		else $error("command B mismatch not flagged");
	a_length_check: assert property (
		in_data && at_end && last_seg && len_bad |=> transmit_error_flag)
		else $error("packet length mismatch not flagged");
	a_overfill_err: assert property (
		push_req && full |=> transmit_error_flag && $stable(wr_ptr_reg))
		else $error("overfill not flagged");
	a_offset_skip: assert property (
		in_data && wcnt_reg < start_word |=> $stable(wr_ptr_reg))
		else $error("bytes before offset were stored");
	a_pad_strip: assert property (
		state_reg == tx_pkg::ST_PAD && word_valid |=> $stable(wr_ptr_reg))
		else $error("padding word was stored");
	a_parse_return: assert property (
		(state_reg == tx_pkg::ST_DATA || state_reg == tx_pkg::ST_PAD)
		&& word_valid && wcnt_reg == last_idx |=> state_reg == tx_pkg::ST_CMD_A)
		else $error("parser missed next command A");
	a_status_tag: assert property (
		s_push && scount == '0 && !status_pop
		|=> ##1 status_valid && status_word[31:16] == $past(head.tag, 2))
		else $error("status tag not copied");
	a_done_pulse: assert property (
		pop && head.buf_end && head.ioc |=> tx_done_irq)
		else $error("completion pulse missing");
	a_status_irq: assert property (
		status_irq_en && status_threshold != 8'h00
		&& 8'(scount) >= status_threshold |=> status_irq)
		else $error("status count interrupt missing");
	a_err_sticky: assert property (
		transmit_error_flag && !err_clear |=> transmit_error_flag)
		else $error("error flag dropped without clear");
endmodule

// *** verification/host_model.sv ***
// Purpose: host cpu writing words over the 16-bit write port
// Assumes: one write strobe per half, driven just after a clock edge
// Notes:   after each word the data lines show the inverse, not stale data

`timescale 1ns/1ps

module host_model (
	// clock
	input  wire logic           clk,
	// half-word writes toward the block
	output tx_pkg::host_write_t hw
);
	initial begin
		hw = '0;
	end

	task automatic put(input logic [31:0] w);
		@(posedge clk);
		#1;
		hw.wr = 1'b1;
		hw.data = w[15:0];
		@(posedge clk);
		#1;
		hw.data = w[31:16];
		@(posedge clk);
		#1;
		hw.wr = 1'b0;
		hw.data = ~w[31:16];
	endtask
endmodule

// *** verification/tx_buffer_command_path_tb.sv ***
// Purpose: self-checking bench for the transmit command path
// Assumes: host_model drives the write port
// Notes:   byte n of a buffer carries base+n, so payload is predictable

`timescale 1ns/1ps

module tx_buffer_command_path_tb;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	tx_pkg::host_write_t host_wr;
	logic                status_pop = 1'b0;
	logic [7:0]          status_threshold = 8'h02;
	logic                status_irq_en = 1'b0;
	logic                err_clear = 1'b0;
	logic                tx_byte_ready = 1'b1;
	logic                tx_byte_valid;
	logic [7:0]          tx_byte;
	logic                tx_byte_last;
	logic                status_valid;
	logic [31:0]         status_word;
	logic                status_irq;
	logic                tx_done_irq;
	logic                transmit_error_flag;
	logic [4:0]          tx_fifo_space_info;
	int                  fails = 0;
	int                  tests_run = 0;
	int                  done_cnt = 0;
	logic [8:0]          got[$];
	logic [8:0]          exp[$];

	always #2.5 clk = ~clk;

	host_model u_host (.clk(clk), .hw(host_wr));

	tx_buffer_command_path #(.DEPTH(16), .SDEPTH(8)) u_tx_buffer_command_path (
		.clk(clk), .rst_n(rst_n), .host_wr(host_wr),
		.status_pop(status_pop), .status_threshold(status_threshold),
		.status_irq_en(status_irq_en), .err_clear(err_clear),
		.tx_byte_ready(tx_byte_ready), .tx_byte_valid(tx_byte_valid),
		.tx_byte(tx_byte), .tx_byte_last(tx_byte_last),
		.status_valid(status_valid), .status_word(status_word),
		.status_irq(status_irq), .tx_done_irq(tx_done_irq),
		.transmit_error_flag(transmit_error_flag),
		.tx_fifo_space_info(tx_fifo_space_info));

	always @(posedge clk) begin
		if (tx_byte_valid === 1'b1 && tx_byte_ready === 1'b1)
			got.push_back({tx_byte_last, tx_byte});
		if (tx_done_irq === 1'b1)
			done_cnt++;
	end

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic limit(input int i, input int n);
		if (i >= n) begin
			fails++;
			$display("BAD %0t wait ran out", $time);
			print_verdict();
		end
	endtask

	task automatic send_buf(input logic ioc, input logic [1:0] al,
		input int off, input int size, input logic [15:0] tag,
		input int len, input logic fs, input logic ls,
		input logic [7:0] base, input logic room);
		int n;
		logic [31:0] w;
		n = (off + size - 1) / 4 + 1;
		if (al == tx_pkg::ALIGN_16)
			n = (n + 3) / 4 * 4;
		if (room)
			chk(tx_fifo_space_info >= n + 2, "no room");
		w = '0;
		w[tx_pkg::IOC_BIT] = ioc;
		w[tx_pkg::ALIGN_HI:tx_pkg::ALIGN_LO] = al;
		w[tx_pkg::OFF_HI:tx_pkg::OFF_LO] = off[4:0];
		w[tx_pkg::FIRST_BIT] = fs;
		w[tx_pkg::LAST_BIT] = ls;
		w[tx_pkg::SIZE_HI:tx_pkg::SIZE_LO] = size[10:0];
		u_host.put(w);
		u_host.put({tag, 5'h00, len[10:0]});
		for (int j = 0; j < n; j++) begin
			for (int k = 0; k < 4; k++)
				w[8*k +: 8] = base + 8'(4*j + k);
			u_host.put(w);
		end
		for (int b = off; b < off + size; b++)
			exp.push_back({ls && b == off + size - 1, base + 8'(b)});
	endtask

	task automatic check_bytes(input string m);
		int i;
		i = 0;
		while (got.size() < exp.size() && i < 2000) begin
			tick(1);
			i++;
		end
		limit(i, 2000);
		tick(4);
		chk(got.size() == exp.size(), m);
		foreach (exp[k])
			if (k < got.size())
				chk(got[k] === exp[k], m);
		got.delete();
		exp.delete();
	endtask

	task automatic pop_status(input logic [15:0] hi, input logic [15:0] lo,
		input string m);
		int i;
		i = 0;
		while (status_valid !== 1'b1 && i < 200) begin
			tick(1);
			i++;
		end
		limit(i, 200);
		chk(status_word === {hi, lo}, m);
		status_pop = 1'b1;
		tick(1);
		status_pop = 1'b0;
		tick(2);
	endtask

	task automatic t_single();
		send_buf(1'b1, 2'h0, 29, 6, 16'hA5C3, 6, 1, 1, 8'h10, 1);
		check_bytes("single buffer bytes");
		chk(done_cnt == 1, "done pulse");
		chk(transmit_error_flag === 1'b0, "spurious error");
		pop_status(16'hA5C3, 16'h0000, "single status");
		$display("single buffer done");
	endtask

	task automatic t_split();
		send_buf(1'b0, tx_pkg::ALIGN_16, 3, 5, 16'h1234, 12, 1, 0, 8'h40, 1);
		send_buf(1'b0, tx_pkg::ALIGN_16, 2, 7, 16'h1234, 12, 0, 1, 8'h80, 1);
		check_bytes("split bytes");
		chk(done_cnt == 1, "done without ioc");
		chk(transmit_error_flag === 1'b0, "split error");
		pop_status(16'h1234, 16'h0000, "split status");
		$display("split packet done");
	endtask

	task automatic t_bad(input logic [15:0] tag2, input int size);
		send_buf(1'b0, 2'h0, 0, 4, 16'h1111, 8, 1, 0, 8'h00, 1);
		send_buf(1'b0, 2'h0, 0, size, tag2, 8, 0, 1, 8'h20, 1);
		tick(60);
		got.delete();
		exp.delete();
		chk(transmit_error_flag === 1'b1, "error not raised");
		pop_status(16'h1111, 16'h8000, "error status");
		err_clear = 1'b1;
		tick(1);
		err_clear = 1'b0;
		tick(1);
		chk(transmit_error_flag === 1'b0, "error not cleared");
		$display("error packet done");
	endtask

	task automatic t_irq();
		send_buf(1'b0, 2'h0, 0, 4, 16'h0001, 4, 1, 1, 8'h00, 1);
		send_buf(1'b0, 2'h0, 0, 8, 16'h0002, 8, 1, 1, 8'h30, 1);
		check_bytes("irq bytes");
		tick(4);
		chk(status_irq === 1'b0, "irq not masked");
		status_irq_en = 1'b1;
		tick(2);
		chk(status_irq === 1'b1, "irq missing");
		status_threshold = 8'h00;
		tick(2);
		chk(status_irq === 1'b0, "irq not off at zero count");
		status_threshold = 8'h02;
		tick(2);
		chk(status_irq === 1'b1, "irq missing after restore");
		pop_status(16'h0001, 16'h0000, "irq status a");
		chk(status_irq === 1'b0, "irq below count");
		pop_status(16'h0002, 16'h0000, "irq status b");
		$display("status count done");
	endtask

	task automatic t_overfill();
		tx_byte_ready = 1'b0;
		send_buf(1'b0, 2'h0, 0, 100, 16'h0003, 100, 1, 1, 8'h00, 0);
		tick(2);
		chk(transmit_error_flag === 1'b1, "overfill unseen");
		$display("overfill done");
	endtask

	initial begin
		tick(4);
		rst_n = 1'b1;
		tick(1);
		chk(tx_fifo_space_info === 5'h10, "space after reset");
		chk(status_valid === 1'b0, "status after reset");
		chk(status_word === 32'h00000000, "status word after reset");
		t_single();
		t_split();
		t_bad(16'h2222, 4);
		t_bad(16'h1111, 5);
		t_irq();
		t_overfill();
		print_verdict();
	end
endmodule
